/* File: hw/adcsq_top.sv */
// adcsq_top: converter sequencer, accumulator, buffer, monitor, comparator control
`timescale 1ns/1ps
module adcsq_top
	import adcsq_pkg::*;
#(
	parameter int BUF_W = ADCSQ_BUF_W
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// conversion control
	input  wire logic                    enable_i,
	input  wire logic                    start_i,
	input  wire logic                    continuous_i,
	input  wire logic [2:0]              channel_i,
	input  wire logic [1:0]              clk_div_i,
	input  wire logic [1:0]              samp_sel_i,
	input  wire logic                    range_double_i,
	input  wire logic                    ref_external_i,
	input  wire logic [1:0]              acc_sel_i,
	input  wire logic                    acc_en_i,
	input  wire logic                    acc_int_only_i,
	input  wire logic                    done_ack_i,
	// analog core
	input  wire logic                    conv_ready_i,
	input  wire logic [ADCSQ_RES_W-1:0]  conversion_result_i,
	output logic                         sample_o,
	output logic                         hold_o,
	output logic [2:0]                   mux_sel_o,
	output logic                         supply_div_en_o,
	output logic                         range_double_o,
	output logic                         ref_external_o,
	output logic [ADCSQ_RES_W-1:0]       result_o,
	output logic [ADCSQ_ACC_W-1:0]       acc_sum_o,
	output logic                         done_o,
	output logic                         eoc_irq_o,
	// sample buffer
	input  wire logic                    buf_mode_i,
	input  wire logic [15:0]             timer_period_i,
	input  wire logic [ADCSQ_NCH-1:0]    buf_ch_mask_i,
	input  wire logic [BUF_W-1:0]        buf_len_i,
	input  wire logic                    buf_wrap_i,
	input  wire logic                    buf_half_ie_i,
	input  wire logic                    buf_full_ie_i,
	input  wire logic                    buf_ovf_ie_i,
	input  wire logic                    buf_clr_i,
	output adcsq_dma_t                   dma_o,
	output logic                         buf_half_irq_o,
	output logic                         buf_full_irq_o,
	output logic                         buf_ovf_irq_o,
	// digital monitor
	input  wire logic [ADCSQ_RES_W-1:0]  monitor_upper_threshold_i,
	input  wire logic [ADCSQ_RES_W-1:0]  monitor_lower_threshold_i,
	input  wire adcsq_mon_t              mon_cond_i,
	input  wire logic                    mon_ie_i,
	output logic                         monitor_output_pin_o,
	output logic                         mon_irq_o,
	// analog comparator
	input  wire adcsq_cmp_cfg_t          cmp_cfg_i,
	input  wire logic                    sleep_i,
	input  wire logic                    analog_comparator_i,
	input  wire logic                    cmp_ie_i,
	output adcsq_cmp_cfg_t               cmp_ctl_o,
	output logic                         cmp_state_o,
	output logic                         cmp_irq_o,
	output logic                         wake_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONV
	} adcsq_state_t;

	adcsq_state_t          state_q;
	logic                  tick;
	logic [5:0]            cyc_q;
	logic [4:0]            samp_cyc;
	logic [5:0]            conv_cyc;
	logic                  finish;
	logic [ADCSQ_RES_W-1:0] res_q;
	logic                  go;
	logic [2:0]            ch_q;
	logic                  seq_busy_q;
	logic [ADCSQ_NCH-1:0]  pend_q;
	logic [2:0]            next_ch;
	logic                  next_any;

	// sample clocks: 2, 4, 6, 8
	function automatic logic [4:0] samp_len(input logic [1:0] sel);
		return {2'h0, sel, 1'b0} + 5'h2;
	endfunction : samp_len

	function automatic logic mon_hit(input logic [ADCSQ_RES_W-1:0] v,
	                                 input logic [ADCSQ_RES_W-1:0] lo,
	                                 input logic [ADCSQ_RES_W-1:0] hi,
	                                 input adcsq_mon_t c);
		logic below;
		logic above;
		below = v < lo;
		above = v > hi;
		case (c)
			ADCSQ_MON_BELOW:  return below;
			ADCSQ_MON_ABOVE:  return above;
			ADCSQ_MON_INSIDE: return !below && !above;
			default:          return below || above;
		endcase
	endfunction : mon_hit

	assign samp_cyc = samp_len(samp_sel_i); // [R3] [R6]
	// conversion total = 3 * sample + 13 converter clocks
	assign conv_cyc = 6'(ADCSQ_CONV_MULT) * {1'b0, samp_cyc} + 6'(ADCSQ_CONV_FIXED); // [R4]

	adcsq_clkdiv u_div (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.run_i     (enable_i),
		.div_sel_i (clk_div_i),
		.tick_o    (tick)
	);

	// ------------------------------------------------------------
	// trigger timer and channel sequencing
	// ------------------------------------------------------------
	logic [15:0] tmr_q;
	logic        trig;

	assign trig = buf_mode_i && enable_i && (tmr_q == timer_period_i);

	always_ff @(posedge clk_i) begin
		if (rst_i || !buf_mode_i || !enable_i) begin
			tmr_q <= 16'h0;
		end else begin
			tmr_q <= trig ? 16'h0 : tmr_q + 16'h1; // [R9]
		end
	end

	always_comb begin
		next_ch  = 3'h0;
		next_any = 1'b0;
		for (int i = ADCSQ_NCH - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				next_ch  = 3'(i);
				next_any = 1'b1;
			end
		end
	end

	// a trigger landing mid-sweep is dropped; the sweep must end first
	always_ff @(posedge clk_i) begin
		if (rst_i || !buf_mode_i) begin
			pend_q     <= '0;
			seq_busy_q <= 1'b0;
		end else if (trig && !seq_busy_q) begin
			pend_q     <= buf_ch_mask_i; // [R13]
			seq_busy_q <= |buf_ch_mask_i;
		end else if (state_q == ST_IDLE && next_any) begin
			pend_q[next_ch] <= 1'b0;
		end else if (state_q == ST_IDLE && !next_any) begin
			seq_busy_q <= 1'b0;
		end
	end

	// software start only outside buffer mode
	assign go = enable_i && (buf_mode_i ? next_any
	                                    : (start_i || continuous_i)); // [R5] [R9]

	// ------------------------------------------------------------
	// conversion state machine
	// ------------------------------------------------------------
	assign finish = (state_q == ST_CONV) && tick && (cyc_q == conv_cyc - 6'h1) && conv_ready_i;

	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i) begin
			state_q <= ST_IDLE;
			cyc_q   <= 6'h0;
			ch_q    <= 3'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					cyc_q <= 6'h0;
					if (go) begin
						state_q <= ST_SAMPLE;
						ch_q    <= buf_mode_i ? next_ch : channel_i; // [R1]
					end
				end
				ST_SAMPLE: begin
					if (tick) begin
						cyc_q <= cyc_q + 6'h1;
						if (cyc_q == {1'b0, samp_cyc} - 6'h1) begin
							state_q <= ST_CONV; // [R3]
						end
					end
				end
				ST_CONV: begin
					if (tick && cyc_q != conv_cyc - 6'h1) begin
						cyc_q <= cyc_q + 6'h1;
					end
					if (finish) begin
						state_q <= ST_IDLE; // [R4] [R5]
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_o        <= 1'b0;
			hold_o          <= 1'b0;
			mux_sel_o       <= 3'h0;
			supply_div_en_o <= 1'b0;
			range_double_o  <= 1'b0;
			ref_external_o  <= 1'b0;
		end else begin
			sample_o        <= state_q == ST_SAMPLE;
			hold_o          <= state_q == ST_CONV;
			mux_sel_o       <= ch_q;
			// divider draws current, so power it only during its own conversion
			supply_div_en_o <= state_q != ST_IDLE && ch_q == ADCSQ_CH_SUPPLY; // [R14]
			range_double_o  <= range_double_i; // [R15]
			ref_external_o  <= ref_external_i; // [R15]
		end
	end

	// ------------------------------------------------------------
	// result, accumulator, completion
	// ------------------------------------------------------------
	logic [4:0] acc_cnt_q;
	logic [4:0] acc_target;
	logic       acc_last;

	assign acc_target = 5'h2 << acc_sel_i;
	assign acc_last   = acc_cnt_q == acc_target - 5'h1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res_q     <= '0;
			result_o  <= '0;
			acc_sum_o <= '0;
			acc_cnt_q <= 5'h0;
		end else if (finish) begin
			res_q    <= conversion_result_i;
			result_o <= conversion_result_i; // [R1]
			if (acc_en_i) begin
				// first sample of a batch restarts the sum; software scales it
				acc_sum_o <= (acc_cnt_q == 5'h0 ? '0 : acc_sum_o)
				             + ADCSQ_ACC_W'(conversion_result_i); // [R8]
				acc_cnt_q <= acc_last ? 5'h0 : acc_cnt_q + 5'h1;
			end
		end
		if (!acc_en_i) begin
			acc_cnt_q <= 5'h0; // [R8]
		end
	end

	logic eoc_evt;
	assign eoc_evt = finish && (!acc_en_i || !acc_int_only_i || acc_last); // [R8]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_o    <= 1'b0;
			eoc_irq_o <= 1'b0;
		end else begin
			// new completion beats a same-cycle acknowledge
			done_o    <= eoc_evt || (done_o && !done_ack_i); // [R7] [R23]
			eoc_irq_o <= eoc_evt; // [R7]
		end
	end

	// ------------------------------------------------------------
	// sample buffer DMA
	// ------------------------------------------------------------
	logic [BUF_W-1:0] wr_q;
	logic             buf_full_q;
	logic             last_word;

	assign last_word = wr_q == buf_len_i - BUF_W'(1);

	always_ff @(posedge clk_i) begin
		if (rst_i || buf_clr_i) begin
			wr_q           <= '0;
			buf_full_q     <= 1'b0;
			dma_o          <= '0;
			buf_half_irq_o <= 1'b0;
			buf_full_irq_o <= 1'b0;
			buf_ovf_irq_o  <= 1'b0;
		end else begin
			dma_o.valid    <= 1'b0;
			buf_half_irq_o <= 1'b0;
			buf_full_irq_o <= 1'b0;
			buf_ovf_irq_o  <= 1'b0;
			if (finish && buf_mode_i) begin
				if (buf_full_q && !buf_wrap_i) begin
					buf_ovf_irq_o <= buf_ovf_ie_i; // [R24] [R12]
				end else begin
					dma_o.valid <= 1'b1;
					dma_o.data  <= ADCSQ_WORD_W'(conversion_result_i); // [R10]
					dma_o.index <= wr_q; // [R13]
					if (wr_q == (buf_len_i >> 1) - BUF_W'(1)) begin
						buf_half_irq_o <= buf_half_ie_i; // [R12]
					end
					if (last_word) begin
						buf_full_irq_o <= buf_full_ie_i; // [R12]
						buf_full_q     <= !buf_wrap_i;
						wr_q           <= '0; // [R11]
					end else begin
						wr_q <= wr_q + BUF_W'(1);
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// digital monitor
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			monitor_output_pin_o <= 1'b0;
			mon_irq_o            <= 1'b0;
		end else if (finish) begin
			monitor_output_pin_o <= mon_hit(conversion_result_i, monitor_lower_threshold_i,
			                                monitor_upper_threshold_i, mon_cond_i); // [R21] [R22]
			mon_irq_o            <= mon_ie_i && mon_hit(conversion_result_i,
			                                monitor_lower_threshold_i,
			                                monitor_upper_threshold_i, mon_cond_i); // [R21]
		end else begin
			mon_irq_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// comparator control
	// ------------------------------------------------------------
	logic [2:0] cmp_sync_q;
	logic       cmp_now;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_sync_q <= 3'h0;
		end else begin
			cmp_sync_q <= {cmp_sync_q[1:0], analog_comparator_i};
		end
	end

	// accept a change once the second and third stages agree
	assign cmp_now = (cmp_sync_q[2] == cmp_sync_q[1]) ? cmp_sync_q[1] : cmp_state_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_ctl_o   <= '0;
			cmp_state_o <= 1'b0;
			cmp_irq_o   <= 1'b0;
			wake_o      <= 1'b0;
		end else begin
			cmp_ctl_o           <= cmp_cfg_i; // [R16] [R17] [R18]
			// in sleep force low-power; caller keeps neg source on pins [R20]
			cmp_ctl_o.low_power <= cmp_cfg_i.low_power || sleep_i; // [R19]
			cmp_state_o         <= cmp_cfg_i.enable ? cmp_now : 1'b0; // [R18]
			cmp_irq_o           <= cmp_cfg_i.enable && cmp_ie_i
			                       && (cmp_now != cmp_state_o); // [R18]
			wake_o              <= sleep_i && cmp_cfg_i.enable && cmp_cfg_i.wake_en
			                       && (cmp_now != cmp_state_o)
			                       && (cmp_now == cmp_cfg_i.wake_rising); // [R19]
		end
	end

endmodule : adcsq_top

/* File: pkg/adcsq_pkg.sv */
// adcsq_pkg: constants and types for the converter sequencer
//
// Behaviour
// [R1] 10-bit result from one of eight inputs: six pins, temperature, supply monitor.
// [R2] converter clock is 16 MHz divided to 2, 1, 0.5 or 0.25 MHz.
// [R3] sample for 2, 4, 6 or 8 converter clocks, then hold.
// [R4] conversion lasts three sample periods plus 13 converter clocks.
// [R5] single mode and continuous mode restarting right after each finish.
// [R6] sample period setting defaults to 2 converter clocks.
// [R7] end of conversion raises interrupt and sets pollable completion status.
// [R8] accumulate 2, 4, 8 or 16 results; optional interrupt only at end.
// [R9] buffer mode conversions are started by a dedicated rate timer.
// [R10] buffer mode writes each result as 16-bit DMA word; length up to 2047.
// [R11] with wrap, write position returns to start after last word.
// [R12] separately enabled half-full, full and overflow interrupts.
// [R13] each trigger converts every selected input into consecutive locations; a trigger landing mid-sweep is dropped.
// [R14] supply divider enabled only while a supply measurement runs.
// [R15] range select: reference or twice reference; reference internal or external.
// [R16] comparator hysteresis selectable 0, 10, 20 or 40 mV.
// [R17] comparator negative from reference or either pin; positive from either pin.
// [R18] comparator output readable, can interrupt, can be disabled entirely.
// [R19] in sleep only low-power comparator; selected edge wakes when enabled.
// [R20] software selects external pins as negative source before sleep.
// [R21] monitor compares each result to thresholds, interrupts, drives a pin.
// [R22] monitor conditions: below, above, inside inclusive, outside.
// [R23] completion flag stays set until acknowledged; new completion sets again.
// [R24] without wrap, result after full is discarded and overflow flagged.
package adcsq_pkg;

	localparam int          ADCSQ_RES_W      = 10;
	localparam int          ADCSQ_NCH        = 8;
	localparam int          ADCSQ_WORD_W     = 16;
	localparam int          ADCSQ_BUF_W      = 11;
	localparam int          ADCSQ_ACC_W      = 14;
	localparam int          ADCSQ_SRC_MHZ    = 16;
	localparam int          ADCSQ_CONV_FIXED = 13;
	localparam int          ADCSQ_CONV_MULT  = 3;
	localparam logic [1:0]  ADCSQ_SAMP_RST   = 2'h0;
	localparam logic [2:0]  ADCSQ_CH_SUPPLY  = 3'h7;
	localparam logic [2:0]  ADCSQ_CH_TEMP    = 3'h6;
	localparam logic [10:0] ADCSQ_BUF_MAX    = 11'h7FF;

	typedef enum logic [1:0] {
		ADCSQ_MON_BELOW,
		ADCSQ_MON_ABOVE,
		ADCSQ_MON_INSIDE,
		ADCSQ_MON_OUTSIDE
	} adcsq_mon_t;

	typedef struct packed {
		logic [1:0]  hyst;
		logic [1:0]  neg_sel;
		logic        pos_sel;
		logic        enable;
		logic        low_power;
		logic        wake_en;
		logic        wake_rising;
	} adcsq_cmp_cfg_t;

	typedef struct packed {
		logic                    valid;
		logic [ADCSQ_WORD_W-1:0] data;
		logic [ADCSQ_BUF_W-1:0]  index;
	} adcsq_dma_t;

endpackage : adcsq_pkg

/* File: hw/adcsq_clkdiv.sv */
// adcsq_clkdiv: converter clock tick generator
`timescale 1ns/1ps
module adcsq_clkdiv
	import adcsq_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic [1:0] div_sel_i,
	output logic            tick_o
);
	logic [2:0] cnt_q;
	logic [2:0] top;

	// 16 MHz / 8, 16, 32, 64 gives 2 MHz down to 250 kHz
	always_comb begin
		top = 3'h7;
		case (div_sel_i)
			2'h0:    top = 3'h7;
			2'h1:    top = 3'h7;
			2'h2:    top = 3'h7;
			default: top = 3'h7;
		endcase
	end

	logic [2:0] pre_q;
	logic       pre_tick;
	logic [2:0] pre_top;

	// wrap at or past the top, so switching to a faster setting never runs a stale long count
	assign pre_top = (3'h1 << div_sel_i) - 3'h1;

	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= (cnt_q == top) ? 3'h0 : cnt_q + 3'h1;
		end
	end

	// second stage counts base ticks for the slower settings
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			pre_q <= 3'h0;
		end else if (cnt_q == top) begin
			pre_q <= (pre_q >= pre_top) ? 3'h0 : pre_q + 3'h1;
		end
	end

	assign pre_tick = (cnt_q == top) && (pre_q >= pre_top);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= run_i && pre_tick; // [R2]
		end
	end

endmodule : adcsq_clkdiv

/* File: tb/adcsq_checker.sv */
// adcsq_checker: port-level assertions for the converter sequencer
`timescale 1ns/1ps
module adcsq_checker
	import adcsq_pkg::*;
#(
	parameter int BUF_W = ADCSQ_BUF_W
) (
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic                   enable_i,
	input wire logic [1:0]             clk_div_i,
	input wire logic [1:0]             samp_sel_i,
	input wire logic                   done_ack_i,
	input wire logic                   acc_int_only_i,
	input wire logic                   sample_o,
	input wire logic                   hold_o,
	input wire logic [2:0]             mux_sel_o,
	input wire logic                   supply_div_en_o,
	input wire logic [ADCSQ_RES_W-1:0] result_o,
	input wire logic                   done_o,
	input wire logic                   eoc_irq_o,
	input wire logic [BUF_W-1:0]       buf_len_i,
	input wire logic                   buf_wrap_i,
	input wire logic                   buf_ovf_ie_i,
	input wire adcsq_dma_t             dma_o,
	input wire logic                   buf_ovf_irq_o,
	input wire logic [ADCSQ_RES_W-1:0] monitor_upper_threshold_i,
	input wire logic [ADCSQ_RES_W-1:0] monitor_lower_threshold_i,
	input wire adcsq_mon_t             mon_cond_i,
	input wire logic                   monitor_output_pin_o,
	input wire logic                   mon_irq_o,
	input wire adcsq_cmp_cfg_t         cmp_cfg_i,
	input wire logic                   sleep_i,
	input wire adcsq_cmp_cfg_t         cmp_ctl_o,
	input wire logic                   wake_o
);
	logic [9:0] samp_cnt_q;
	logic [9:0] per;
	logic [9:0] n_samp;
	logic       below;
	logic       above;
	logic       mon_exp;

	// window allows for the free-running divider phase at start
	always_ff @(posedge clk_i) begin
		if (rst_i || !sample_o) begin
			samp_cnt_q <= 10'h000;
		end else begin
			samp_cnt_q <= samp_cnt_q + 10'h001;
		end
	end
	assign per = 10'h008 << clk_div_i;
	assign n_samp = {7'h00, samp_sel_i, 1'b0} + 10'h002;
	assign below = result_o < monitor_lower_threshold_i;
	assign above = result_o > monitor_upper_threshold_i;
	always_comb begin
		case (mon_cond_i)
			ADCSQ_MON_BELOW: mon_exp = below;
			ADCSQ_MON_ABOVE: mon_exp = above;
			ADCSQ_MON_INSIDE: mon_exp = !below && !above;
			default: mon_exp = below || above;
		endcase
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_samp_len: assert property ($fell(sample_o) && enable_i && $past(enable_i) |->
		samp_cnt_q > (n_samp - 10'h001) * per && samp_cnt_q <= n_samp * per + 10'h001)
		else $error("sample window length off");
	a_done_sticky: assert property (done_o && !done_ack_i |=> done_o)
		else $error("done dropped without ack");
	a_eoc_done: assert property (eoc_irq_o |-> done_o)
		else $error("interrupt without done");
	a_supply_gate: assert property (supply_div_en_o |->
		(sample_o || hold_o) && mux_sel_o == ADCSQ_CH_SUPPLY)
		else $error("supply divider on outside measurement");
	a_dma_word: assert property (dma_o.valid |->
		dma_o.data[15:10] == 6'h00 && dma_o.index < buf_len_i)
		else $error("bad buffer word");
	a_ovf_nowrap: assert property (buf_ovf_irq_o |->
		buf_ovf_ie_i && !buf_wrap_i && !dma_o.valid)
		else $error("overflow flagged wrongly");
	a_mon_cond: assert property (eoc_irq_o && !acc_int_only_i |->
		monitor_output_pin_o == mon_exp)
		else $error("monitor pin mismatch");
	a_mon_irq: assert property (mon_irq_o |-> monitor_output_pin_o)
		else $error("monitor irq without hit");
	a_sleep_lp: assert property ($past(sleep_i) |-> cmp_ctl_o.low_power)
		else $error("comparator not low power in sleep");
	a_cmp_off: assert property (!$past(cmp_cfg_i.enable) |-> !cmp_ctl_o.enable)
		else $error("comparator enabled while off");
	a_wake_sleep: assert property (wake_o |-> $past(sleep_i) && $past(cmp_cfg_i.wake_en))
		else $error("wake outside sleep");

	c_eoc: cover property (eoc_irq_o);
	c_dma: cover property (dma_o.valid);
	c_ovf: cover property (buf_ovf_irq_o);
	c_wake: cover property (wake_o);
endmodule : adcsq_checker

/* File: tb/adcsq_analog_model.sv */
// adcsq_analog_model: behavioural converter core answering the sequencer
`timescale 1ns/1ps
module adcsq_analog_model
	import adcsq_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   hold_i,
	input  wire logic [2:0]             mux_i,
	input  wire logic [ADCSQ_RES_W-1:0] level_i,
	input  wire logic [8:0]             delay_i,
	output logic                        ready_o,
	output logic [ADCSQ_RES_W-1:0]      result_o
);
	logic [8:0] wait_q;

	always_ff @(posedge clk_i) begin
		if (!hold_i) begin
			wait_q <= 9'h000;
		end else if (wait_q != 9'h1FF) begin
			wait_q <= wait_q + 9'h001;
		end
	end
	// large delay_i makes the core late, so finish has to wait
	assign ready_o = hold_i && (wait_q >= delay_i);
	// outside hold the result toggles so a stale value cannot pass
	always_ff @(posedge clk_i) begin
		if (hold_i) begin
			result_o <= level_i ^ {7'h00, mux_i};
		end else begin
			result_o <= ~result_o;
		end
	end
endmodule : adcsq_analog_model

/* File: tb/tb_top.sv */
// tb_top: self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top
	import adcsq_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1, enable_i = 1'b0, start_i = 1'b0, continuous_i = 1'b0;
	logic range_double_i = 1'b0, ref_external_i = 1'b0, done_ack_i = 1'b0, acc_en_i = 1'b0;
	logic acc_int_only_i = 1'b0, buf_mode_i = 1'b0, buf_wrap_i = 1'b0, buf_clr_i = 1'b0;
	logic mon_ie_i = 1'b1, buf_half_ie_i = 1'b1, buf_full_ie_i = 1'b1, buf_ovf_ie_i = 1'b1;
	logic sleep_i = 1'b0, analog_comparator_i = 1'b0, cmp_ie_i = 1'b1;
	logic [2:0] channel_i = 3'h0;
	logic [1:0] clk_div_i = 2'h0, samp_sel_i = ADCSQ_SAMP_RST, acc_sel_i = 2'h0;
	logic [15:0] timer_period_i = 16'h02BC;
	logic [7:0] buf_ch_mask_i = 8'h01;
	logic [ADCSQ_BUF_W-1:0] buf_len_i = 11'h006;
	logic [9:0] monitor_upper_threshold_i = 10'h000, monitor_lower_threshold_i = 10'h000;
	adcsq_mon_t mon_cond_i = ADCSQ_MON_BELOW;
	adcsq_cmp_cfg_t cmp_cfg_i = '0, cmp_ctl_o, cfg;
	logic conv_ready_i, sample_o, hold_o, supply_div_en_o, range_double_o, ref_external_o;
	logic done_o, eoc_irq_o, buf_half_irq_o, buf_full_irq_o, buf_ovf_irq_o, cmp_irq_o;
	logic monitor_output_pin_o, mon_irq_o, cmp_state_o, wake_o, hold_prev = 1'b0;
	logic [2:0] mux_sel_o;
	logic [9:0] conversion_result_i, result_o, level = 10'h000;
	logic [ADCSQ_ACC_W-1:0] acc_sum_o;
	adcsq_dma_t dma_o, words[$];
	logic [8:0] delay = 9'h000;
	logic [7:0] seen = 8'h00;
	int n_errors = 0, checks_done = 0, cyc = 0, holds = 0;

	adcsq_top u_dut (.*);
	adcsq_analog_model u_ana (.clk_i(clk_i), .hold_i(hold_o), .mux_i(mux_sel_o),
		.level_i(level), .delay_i(delay), .ready_o(conv_ready_i), .result_o(conversion_result_i));

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic ok, input string what);
		checks_done++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) begin
			@(negedge clk_i);
			seen |= {2'h0, supply_div_en_o, buf_ovf_irq_o, buf_full_irq_o, buf_half_irq_o,
				wake_o, cmp_irq_o};
			if (hold_o === 1'b1 && !hold_prev) holds++;
			hold_prev = hold_o;
			if (dma_o.valid === 1'b1) words.push_back(dma_o);
		end
	endtask : step
	task automatic go_wait(output int n);
		@(posedge clk_i);
		start_i <= 1'b1;
		@(posedge clk_i);
		start_i <= 1'b0;
		seen = 8'h00;
		holds = 0;
		n = 0;
		do begin
			step(1);
			n++;
		end while (eoc_irq_o !== 1'b1);
	endtask : go_wait

	initial begin
		int n;
		logic [2:0] ch;
		logic [7:0] m;
		logic [2:0] chans[$];
		void'($urandom(32'h916E));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		enable_i <= 1'b1;
		step(1);
		check(done_o === 1'b0 && dma_o.valid === 1'b0, "reset state");
		for (int k = 0; k < 16; k++) begin
			ch = 3'($urandom_range(7, 0));
			@(posedge clk_i);
			clk_div_i <= k[1:0];
			samp_sel_i <= k[3:2];
			channel_i <= ch;
			level <= 10'($urandom);
			mon_cond_i <= adcsq_mon_t'(k[1:0]);
			monitor_lower_threshold_i <= 10'($urandom);
			monitor_upper_threshold_i <= 10'($urandom);
			range_double_i <= k[2];
			ref_external_i <= k[0];
			go_wait(n);
			m = 8'(3 * (2 * k[3:2] + 2) + 13);
			check(n > (m - 1) * (8 << k[1:0]) && n <= m * (8 << k[1:0]) + 3, "timing");
			check(result_o === (level ^ {7'h00, ch}), "result");
			check(seen[5] === (ch == ADCSQ_CH_SUPPLY), "supply divider");
			check(done_o && range_double_o === k[2] && ref_external_o === k[0], "status");
			@(posedge clk_i);
			done_ack_i <= 1'b1;
			@(posedge clk_i);
			done_ack_i <= 1'b0;
			step(1);
			check(done_o === 1'b0, "done clear");
		end
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_i);
			clk_div_i <= 2'h0;
			samp_sel_i <= 2'h0;
			channel_i <= 3'h0;
			acc_sel_i <= s[1:0];
			acc_en_i <= 1'b1;
			acc_int_only_i <= 1'b1;
			continuous_i <= 1'b1;
			level <= 10'($urandom);
			go_wait(n);
			check(acc_sum_o === ADCSQ_ACC_W'((2 << s) * level), "sum");
			check(holds == (2 << s), "batch length");
			@(posedge clk_i);
			continuous_i <= 1'b0;
			step(2);
			while (sample_o === 1'b1 || hold_o === 1'b1) step(1);
			@(posedge clk_i);
			acc_en_i <= 1'b0;
		end
		m = 8'($urandom) | 8'h01;
		for (int b = 0; b < 8; b++)
			if (m[b]) chans.push_back(3'(b));
		@(posedge clk_i);
		acc_int_only_i <= 1'b0;
		buf_ch_mask_i <= m;
		delay <= 9'h0C8;
		buf_mode_i <= 1'b1;
		words = {};
		seen = 8'h00;
		step(6000);
		check(seen[4:2] === 3'b111 && words.size() == 6, "fill and discard");
		for (int i = 0; i < 6; i++)
			check(words[i].index === 11'(i) && words[i].data === {6'h00,
				level ^ {7'h00, chans[i % chans.size()]}}, "buffer word");
		@(posedge clk_i);
		buf_clr_i <= 1'b1;
		buf_wrap_i <= 1'b1;
		@(posedge clk_i);
		buf_clr_i <= 1'b0;
		words = {};
		seen = 8'h00;
		step(6000);
		check(words.size() > 6 && seen[4] === 1'b0, "wrap count");
		for (int i = 0; i < words.size(); i++)
			check(words[i].index === 11'(i % 6), "wrap index");
		cfg = {2'($urandom), 2'($urandom_range(2, 1)), 1'($urandom), 4'b1011};
		@(posedge clk_i);
		buf_mode_i <= 1'b0;
		cmp_cfg_i <= cfg;
		analog_comparator_i <= 1'b1;
		seen = 8'h00;
		step(8);
		check(cmp_state_o === 1'b1 && seen[1:0] === 2'b01, "compare");
		check(cmp_ctl_o === cfg, "comparator setup");
		@(posedge clk_i);
		sleep_i <= 1'b1;
		analog_comparator_i <= 1'b0;
		step(8);
		check(cmp_ctl_o.low_power === 1'b1 && seen[1] === 1'b0, "sleep fall");
		@(posedge clk_i);
		analog_comparator_i <= 1'b1;
		step(8);
		check(seen[1] === 1'b1, "wake on rise");
		tally_and_finish();
	end
endmodule : tb_top

bind adcsq_top adcsq_checker #(.BUF_W(BUF_W)) u_chk (.*);
